// file: logic/iepr_pkg.sv
// Package with addresses, field positions and types of the register set.
package iepr_pkg;
  localparam logic [7:0] ADDR_AUX   = 8'ha1; // Break, switch, polarity.
  localparam logic [7:0] ADDR_EEN2  = 8'ha5; // Extended enable two.
  localparam logic [7:0] ADDR_EEN1  = 8'had; // Extended enable one.
  localparam logic [7:0] ADDR_EPR1L = 8'hae; // Extended priority one low.
  localparam logic [7:0] ADDR_EPR1H = 8'haf; // Extended priority one high.
  localparam logic [7:0] ADDR_PR0H  = 8'hb7; // Priority zero high.
  localparam logic [7:0] ADDR_PR0L  = 8'hb8; // Priority zero low.
  localparam logic [7:0] ADDR_XCTL  = 8'hc0; // External 2/3 control.
  localparam logic [7:0] RESET_VAL  = 8'h00; // Reset value of all registers.
  // Auxiliary register bits.
  localparam int AUX_BRK = 4;  // Break flag.
  localparam int AUX_M1  = 3;  // Modulator one switch flag.
  localparam int AUX_M0  = 2;  // Modulator zero switch flag.
  localparam int AUX_P1  = 1;  // External 1 polarity.
  localparam int AUX_P0  = 0;  // External 0 polarity.
  // Control register bits; external 3 sits at offset four above 2.
  localparam int XC_POL  = 3;  // Polarity of external 2.
  localparam int XC_EN   = 2;  // Enable of external 2.
  localparam int XC_PND  = 1;  // Pending flag of external 2.
  localparam int XC_TRG  = 0;  // Trigger kind of external 2.
  localparam int XC_HI   = 4;  // Distance to the external 3 field.
  // Extended enable one bits.
  localparam int E1_KBD  = 5;  // Keypad.
  localparam int E1_SF   = 3;  // System flag group.
  localparam int E1_ADC  = 1;  // Converter.
  localparam int E1_SPI  = 0;  // SPI.
  localparam int E2_RSV  = 5;  // Reserved bit of enable two.
  localparam int NSRC    = 24; // Number of interrupt sources.
  localparam int NSF     = 9;  // Flags in the system flag group.
  localparam logic [1:0] LVL_TOP = 2'h3; // Highest priority code.
  localparam logic [1:0] LVL_LOW = 2'h0; // Lowest priority code.
  typedef logic [1:0] iepr_lvl_t;        // Two-bit priority level.
endpackage

// file: logic/iepr_bus_if.sv
// Interface carrying register write and pending-flag events between modules.
`timescale 1ns/10ps
interface iepr_bus_if;
  logic       wr_en;   // Write strobe.
  logic [7:0] addr;    // Register address.
  logic [7:0] wdata;   // Write data.
  logic [1:0] trig;    // Trigger detected for externals 2 and 3.
  logic [1:0] ack;     // Service start for externals 2 and 3.
  logic [7:0] ctl;     // Control register value.
  modport regs (input wr_en, addr, wdata, trig, ack, output ctl);
  modport top  (output wr_en, addr, wdata, trig, ack, input ctl);
endinterface

// file: logic/iepr_xctl.sv
// Control register for externals 2 and 3: pending flags set by triggers that are detected in the top module.
`timescale 1ns/10ps
module iepr_xctl (
  input  wire logic sys_clk,   // System clock.
  input  wire logic rst,       // Asynchronous reset, active high.
  iepr_bus_if.regs  bus        // Bus and event carrier.
);
  logic [7:0] ctl_reg;  // Stored control register.
  logic [7:0] ctl_next; // Next value.
  assign bus.ctl = ctl_reg;

  // Hardware set wins over both service clear and software clear.
  always_comb begin
    ctl_next = ctl_reg;
    if (bus.wr_en && bus.addr == iepr_pkg::ADDR_XCTL) begin
      ctl_next = bus.wdata;
    end
    for (int i = 0; i < 2; i++) begin
      if (bus.ack[i]) begin
        ctl_next[iepr_pkg::XC_PND + i * iepr_pkg::XC_HI] = 1'b0;
      end
      if (bus.trig[i]) begin
        ctl_next[iepr_pkg::XC_PND + i * iepr_pkg::XC_HI] = 1'b1;
      end
    end
  end

  // Register update.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_reg <= iepr_pkg::RESET_VAL;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  a_pend_set: assert property (@(posedge sys_clk) disable iff (rst)
    bus.trig[0] |=> ctl_reg[iepr_pkg::XC_PND])
    else $error("pending flag two not set by trigger");
  a_pend_clr: assert property (@(posedge sys_clk) disable iff (rst)
    (bus.ack[1] && !bus.trig[1] && !bus.wr_en)
      |=> !ctl_reg[iepr_pkg::XC_PND + iepr_pkg::XC_HI])
    else $error("pending flag three not cleared on service");
endmodule

// file: logic/iepr_top.sv
// Interrupt enable, priority and external interrupt control registers.
`timescale 1ns/10ps
module iepr_top (
  input  wire logic        sys_clk,        // System clock, 50 MHz.
  input  wire logic        rst,            // Asynchronous reset.
  input  wire logic        sfr_wr,         // Register write strobe.
  input  wire logic        sfr_rd,         // Register read strobe.
  input  wire logic [7:0]  sfr_addr,       // Register address.
  input  wire logic [7:0]  sfr_wdata,      // Write data.
  output logic      [7:0]  sfr_rdata,      // Read data, one cycle late.
  input  wire logic        global_irq_gate, // Global enable from core.
  input  wire logic        ext_irq_input_3, // External 3 pin, sync.
  input  wire logic        ext_irq_input_2, // External 2 pin, sync.
  input  wire logic [1:0]  ext_svc_ack,    // Service start, 3 and 2.
  input  wire logic        break_event,    // Enabled break source fired.
  input  wire logic        sw_break,       // Software break trigger.
  input  wire logic        signal_modulator_one,  // Modulator 1 switch.
  input  wire logic        signal_modulator_zero, // Modulator 0 switch.
  input  wire logic [5:0]  pwm_chan_en,    // Enabled PWM channels.
  input  wire logic [8:0]  sys_flags,      // System flag group flags.
  input  wire logic [8:0]  system_flag_source_enables, // Their enables.
  input  wire logic [23:0] src_flags,      // Other sources' own flags.
  input  wire logic        power_down,     // Idle or power-down mode.
  output logic      [5:0]  pwm_block,      // PWM channels held blocked.
  output logic             ext0_polarity_high, // External 0 sense.
  output logic             ext1_polarity_high, // External 1 sense.
  output logic      [23:0] irq_req,        // Gated requests.
  output logic      [47:0] irq_level,      // Two-bit level per source.
  output logic             cpu_wake        // Wake request.
);
  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  logic [7:0] aux_break_polarity_flags_reg;   // Break, switch, polarity.
  logic [7:0] extended_enable_two_reg;        // Enable two.
  logic [7:0] extended_enable_one_reg;        // Enable one.
  logic [7:0] extended_priority_one_low_reg;  // Priority one low.
  logic [7:0] extended_priority_one_high_reg; // Priority one high.
  logic [7:0] priority_zero_high_reg;         // Priority zero high.
  logic [7:0] priority_zero_low_reg;          // Priority zero low.
  logic [7:0] aux_next;                       // Next auxiliary value.
  logic [1:0] pin_dly_reg;                    // Last pin samples, 2 and 3.
  logic [1:0] trig;                           // Trigger detected now.
  logic [7:0] ctl;                            // Control register view.
  logic       sf_req;                         // System flag group request.
  logic [23:0] req_next;                      // Next request vector.

  iepr_bus_if bus ();
  assign bus.wr_en = sfr_wr;
  assign bus.addr  = sfr_addr;
  assign bus.wdata = sfr_wdata;
  assign bus.trig  = trig;
  assign bus.ack   = ext_svc_ack; // Bit 0 is external 2, bit 1 external 3.
  assign ctl       = bus.ctl;

  iepr_xctl u_xctl (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (bus)
  );

  // Returns true when a write hits the given address.
  function automatic logic hit(input logic [7:0] a);
    return sfr_wr && sfr_addr == a;
  endfunction

  // Maps a bit of the extended priority one pair to its source number.
  function automatic int ext_one_slot(input int b);
    case (b)
      4:       return 14; // Serial 1.
      5:       return 11; // Keypad.
      6:       return 12; // Two-wire 0.
      7:       return 13; // Comparator 0.
      default: return b + 7; // SPI, converter, counter array, system flag.
    endcase
  endfunction

  // Detects the configured condition on one pin: level or edge, per sense.
  function automatic logic detect(input logic pin, input logic prev,
                                  input logic pol, input logic edg);
    logic act;
    logic act_prev;
    act      = pin ~^ pol;  // Active when pin matches sense.
    act_prev = prev ~^ pol;
    return edg ? (act && !act_prev) : act;
  endfunction

  // ----------------------------------------------------------------------
  // External 2 and 3 detection.
  // ----------------------------------------------------------------------
  // Remember pins so edges can be seen.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_dly_reg <= 2'h3;
    end else begin
      pin_dly_reg <= {ext_irq_input_3, ext_irq_input_2};
    end
  end

  // Index 0 is external 2, index 1 external 3.
  always_comb begin
    trig[0] = detect(ext_irq_input_2, pin_dly_reg[0],
                     ctl[iepr_pkg::XC_POL], ctl[iepr_pkg::XC_TRG]);
    trig[1] = detect(ext_irq_input_3, pin_dly_reg[1],
                     ctl[iepr_pkg::XC_POL + iepr_pkg::XC_HI],
                     ctl[iepr_pkg::XC_TRG + iepr_pkg::XC_HI]);
  end

  // ----------------------------------------------------------------------
  // Auxiliary register: sticky flags, set wins over software clear.
  // ----------------------------------------------------------------------
  always_comb begin
    aux_next = aux_break_polarity_flags_reg;
    if (hit(iepr_pkg::ADDR_AUX)) begin
      aux_next = sfr_wdata;
    end
    if (break_event || sw_break) begin
      aux_next[iepr_pkg::AUX_BRK] = 1'b1;
    end
    if (signal_modulator_one) begin
      aux_next[iepr_pkg::AUX_M1] = 1'b1;
    end
    if (signal_modulator_zero) begin
      aux_next[iepr_pkg::AUX_M0] = 1'b1;
    end
  end

  // Auxiliary register storage.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aux_break_polarity_flags_reg <= iepr_pkg::RESET_VAL;
    end else begin
      aux_break_polarity_flags_reg <= aux_next;
    end
  end

  // ----------------------------------------------------------------------
  // Enable and priority registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      extended_enable_two_reg <= iepr_pkg::RESET_VAL;
    end else if (hit(iepr_pkg::ADDR_EEN2)) begin
      // Reserved bit five is kept at zero in case software sets it.
      extended_enable_two_reg <= sfr_wdata & ~(8'h01 << iepr_pkg::E2_RSV);
    end
  end

  // Enable one, written whole.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      extended_enable_one_reg <= iepr_pkg::RESET_VAL;
    end else if (hit(iepr_pkg::ADDR_EEN1)) begin
      extended_enable_one_reg <= sfr_wdata;
    end
  end

  // Priority registers, each written whole.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      extended_priority_one_low_reg  <= iepr_pkg::RESET_VAL;
      extended_priority_one_high_reg <= iepr_pkg::RESET_VAL;
      priority_zero_high_reg         <= iepr_pkg::RESET_VAL;
      priority_zero_low_reg          <= iepr_pkg::RESET_VAL;
    end else begin
      if (hit(iepr_pkg::ADDR_EPR1L)) begin
        extended_priority_one_low_reg <= sfr_wdata;
      end
      if (hit(iepr_pkg::ADDR_EPR1H)) begin
        extended_priority_one_high_reg <= sfr_wdata;
      end
      if (hit(iepr_pkg::ADDR_PR0H)) begin
        priority_zero_high_reg <= sfr_wdata;
      end
      if (hit(iepr_pkg::ADDR_PR0L)) begin
        priority_zero_low_reg <= sfr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port: unmapped addresses read zero.
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= iepr_pkg::RESET_VAL;
    end else if (sfr_rd) begin
      case (sfr_addr)
        iepr_pkg::ADDR_AUX:   sfr_rdata <= aux_break_polarity_flags_reg;
        iepr_pkg::ADDR_EEN2:  sfr_rdata <= extended_enable_two_reg;
        iepr_pkg::ADDR_EEN1:  sfr_rdata <= extended_enable_one_reg;
        iepr_pkg::ADDR_EPR1L: sfr_rdata <= extended_priority_one_low_reg;
        iepr_pkg::ADDR_EPR1H: sfr_rdata <= extended_priority_one_high_reg;
        iepr_pkg::ADDR_PR0H:  sfr_rdata <= priority_zero_high_reg;
        iepr_pkg::ADDR_PR0L:  sfr_rdata <= priority_zero_low_reg;
        iepr_pkg::ADDR_XCTL:  sfr_rdata <= ctl;
        default:              sfr_rdata <= iepr_pkg::RESET_VAL;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Request gating.
  // ----------------------------------------------------------------------
  assign sf_req = |(sys_flags & system_flag_source_enables);

  // Source numbering follows the service order: 0..6 in the base group
  // (external 0, timer 0, external 2, timer 1, serial 0, timer 2, DMA),
  // then enable one, external 3 and enable two.
  always_comb begin
    req_next = src_flags;
    req_next[2]  = ctl[iepr_pkg::XC_PND] & ctl[iepr_pkg::XC_EN];
    req_next[15] = ctl[iepr_pkg::XC_PND + iepr_pkg::XC_HI]
                 & ctl[iepr_pkg::XC_EN + iepr_pkg::XC_HI];
    req_next[7]  = src_flags[7] & extended_enable_one_reg[iepr_pkg::E1_SPI];
    req_next[8]  = src_flags[8] & extended_enable_one_reg[iepr_pkg::E1_ADC];
    req_next[9]  = src_flags[9] & extended_enable_one_reg[2];
    req_next[10] = sf_req & extended_enable_one_reg[iepr_pkg::E1_SF];
    req_next[11] = src_flags[11] & extended_enable_one_reg[iepr_pkg::E1_KBD];
    req_next[12] = src_flags[12] & extended_enable_one_reg[6];
    req_next[13] = src_flags[13] & extended_enable_one_reg[7];
    req_next[14] = src_flags[14] & extended_enable_one_reg[4];
    req_next[16] = src_flags[16] & extended_enable_two_reg[0];
    req_next[17] = src_flags[17] & extended_enable_two_reg[1];
    req_next[19] = src_flags[19] & extended_enable_two_reg[7];
    req_next[20] = src_flags[20] & extended_enable_two_reg[2];
    req_next[21] = src_flags[21] & extended_enable_two_reg[3];
    req_next[22] = src_flags[22] & extended_enable_two_reg[4];
    req_next[23] = src_flags[23] & extended_enable_two_reg[6];
    if (!global_irq_gate) begin
      req_next = '0;
    end
  end

  // Registered requests, wake, break blocking and polarity outputs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_req            <= '0;
      cpu_wake           <= 1'b0;
      pwm_block          <= '0;
      ext0_polarity_high <= 1'b0;
      ext1_polarity_high <= 1'b0;
    end else begin
      irq_req   <= req_next;
      // Wake only from an enabled external 2 or 3 pending flag.
      cpu_wake  <= power_down &&
                   ((ctl[iepr_pkg::XC_PND] && ctl[iepr_pkg::XC_EN]) ||
                    (ctl[iepr_pkg::XC_PND + iepr_pkg::XC_HI] &&
                     ctl[iepr_pkg::XC_EN + iepr_pkg::XC_HI]));
      pwm_block <= pwm_chan_en &
                   {6{aux_break_polarity_flags_reg[iepr_pkg::AUX_BRK]}};
      ext0_polarity_high <= aux_break_polarity_flags_reg[iepr_pkg::AUX_P0];
      ext1_polarity_high <= aux_break_polarity_flags_reg[iepr_pkg::AUX_P1];
    end
  end

  // Priority levels {high,low}; sources 19..23 only reach the top level.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_level <= '0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        irq_level[2*i +: 2] <= {priority_zero_high_reg[i],
                                priority_zero_low_reg[i]};
      end
      for (int i = 0; i < 8; i++) begin
        irq_level[2*ext_one_slot(i) +: 2] <=
          {extended_priority_one_high_reg[i],
           extended_priority_one_low_reg[i]};
      end
      irq_level[2*15 +: 2] <= {priority_zero_high_reg[7],
                               priority_zero_low_reg[7]};
      // Sources 16..18 keep the lowest level; 19..23 have only the top one.
      for (int i = 16; i < iepr_pkg::NSRC; i++) begin
        irq_level[2*i +: 2] <= (i >= 19) ? iepr_pkg::LVL_TOP
                                         : iepr_pkg::LVL_LOW;
      end
    end
  end

  a_break_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (aux_break_polarity_flags_reg[iepr_pkg::AUX_BRK] &&
     !hit(iepr_pkg::ADDR_AUX))
      |=> aux_break_polarity_flags_reg[iepr_pkg::AUX_BRK])
    else $error("break flag cleared without a write");
  a_break_block: assert property (@(posedge sys_clk) disable iff (rst)
    aux_break_polarity_flags_reg[iepr_pkg::AUX_BRK] ##1
      aux_break_polarity_flags_reg[iepr_pkg::AUX_BRK]
      |-> pwm_block == pwm_chan_en ||
          $past(pwm_chan_en) == pwm_block)
    else $error("enabled channels not blocked");
  a_mod_set: assert property (@(posedge sys_clk) disable iff (rst)
    signal_modulator_one |=> aux_break_polarity_flags_reg[iepr_pkg::AUX_M1])
    else $error("modulator one flag not set");
  a_gate_off: assert property (@(posedge sys_clk) disable iff (rst)
    !global_irq_gate |=> irq_req == '0)
    else $error("request passed with global gate clear");
  a_rsv_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !extended_enable_two_reg[iepr_pkg::E2_RSV])
    else $error("reserved enable bit set");
  a_sf_group: assert property (@(posedge sys_clk) disable iff (rst)
    (global_irq_gate && extended_enable_one_reg[iepr_pkg::E1_SF] && sf_req)
      |=> irq_req[10])
    else $error("system flag request missing");
  a_no_wake: assert property (@(posedge sys_clk) disable iff (rst)
    !ctl[iepr_pkg::XC_EN] && !ctl[iepr_pkg::XC_EN + iepr_pkg::XC_HI]
      |=> !cpu_wake)
    else $error("wake with both enables clear");
endmodule

// file: tb/iepr_cpu_model.sv
// Core model that issues register reads and writes to the block.
`timescale 1ns/10ps
module iepr_cpu_model (
  input  wire logic       sys_clk,   // System clock.
  input  wire logic [7:0] sfr_rdata, // Read data from the block.
  output logic            sfr_wr,    // Write strobe.
  output logic            sfr_rd,    // Read strobe.
  output logic      [7:0] sfr_addr,  // Register address.
  output logic      [7:0] sfr_wdata  // Write data.
);
  // Bus starts idle; strobes low at time zero.
  initial begin
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
  end
  // One write; the reserved enable bit goes out as zero unless raw is set.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
    @(negedge sys_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    if (a == iepr_pkg::ADDR_EEN2 && !raw) begin
      sfr_wdata[iepr_pkg::E2_RSV] = 1'b0;
    end
    sfr_wr    = 1'b1;
    @(negedge sys_clk);
    sfr_wr    = 1'b0;
    sfr_addr  = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
  endtask
  // One read; data is taken half a cycle after the strobe was sampled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge sys_clk);
    sfr_rd   = 1'b0;
    sfr_addr = ~a;
    d        = sfr_rdata;
  endtask
endmodule

// file: tb/tb_iepr_top.sv
// Self-checking testbench of the interrupt enable and priority registers.
`timescale 1ns/10ps
module tb_iepr_top;
  logic        sys_clk, rst, gate, pd, wr, rd, wake; // Clock, controls.
  logic [1:0]  pin, ack, pol;   // External 3/2 pins, service, polarity.
  logic [3:0]  ev;              // Break, soft break, modulator 1, 0.
  logic [5:0]  pwm_en, blk;     // PWM channel enables and blocks.
  logic [8:0]  sf, sf_en;       // System flags and their enables.
  logic [7:0]  addr, wdata, rdata; // Register bus.
  logic [23:0] req;             // Gated requests.
  logic [47:0] lvl;             // Priority levels.
  int          error_cnt, n_compared; // Mismatch and compare counts.
  localparam logic [7:0] XC = iepr_pkg::ADDR_XCTL; // Control register.
  localparam logic [7:0] AX = iepr_pkg::ADDR_AUX;  // Auxiliary register.
  localparam logic [7:0] P[4] = '{8'h5a, 8'h3c, 8'hc6, 8'h93}; // Levels.
  localparam logic [7:0] E1[3] = '{8'hff, 8'h5a, 8'hff}; // Enable one.
  localparam logic [7:0] E2[3] = '{8'hdf, 8'h93, 8'hdf}; // Enable two.
  localparam int M1[8] = '{7, 8, 9, 10, 14, 11, 12, 13}; // Bit to slot.
  localparam int M2[8] = '{16, 17, 20, 21, 22, 18, 23, 19}; // Bit to slot.

  iepr_cpu_model u_cpu (.sys_clk(sys_clk), .sfr_rdata(rdata), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_addr(addr), .sfr_wdata(wdata));
  iepr_top u_dut (.sys_clk(sys_clk), .rst(rst), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_addr(addr), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .global_irq_gate(gate), .ext_irq_input_3(pin[1]),
    .ext_irq_input_2(pin[0]), .ext_svc_ack(ack), .break_event(ev[3]),
    .sw_break(ev[2]), .signal_modulator_one(ev[1]),
    .signal_modulator_zero(ev[0]), .pwm_chan_en(pwm_en), .sys_flags(sf),
    .system_flag_source_enables(sf_en), .src_flags(24'hffffff),
    .power_down(pd), .pwm_block(blk), .ext0_polarity_high(pol[0]),
    .ext1_polarity_high(pol[1]), .irq_req(req), .irq_level(lvl),
    .cpu_wake(wake));

  // Clock of 20 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Reads a register and compares it.
  task automatic rdchk(logic [7:0] a, logic [7:0] exp);
    logic [7:0] v;
    u_cpu.rd(a, v);
    chk($sformatf("register %h", a), 48'(v), 48'(exp));
  endtask
  // Waits a number of falling edges.
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [47:0] e;
    logic [7:0]  c, pb;
    int          k;
    logic        pl, tg, en;
    {rst, gate, pd, ack, ev, pin} = {3'b100, 2'b00, 4'h0, 2'b11};
    {pwm_en, sf, sf_en} = {6'h2b, 9'h001, 9'h001};
    error_cnt = 0;
    n_compared = 0;
    cyc(10);
    rst = 1'b0;
    // Enable one, priority one low, control and auxiliary registers read zero after reset, unmapped 8'hac too.
    foreach (E1[i]) rdchk(8'hac + 8'(i), 8'h00);
    rdchk(XC, 8'h00);
    rdchk(AX, 8'h00);
    // Priority levels from the four priority registers.
    u_cpu.wr(iepr_pkg::ADDR_PR0L, P[0], 1'b0);
    u_cpu.wr(iepr_pkg::ADDR_PR0H, P[1], 1'b0);
    u_cpu.wr(iepr_pkg::ADDR_EPR1L, P[2], 1'b0);
    u_cpu.wr(iepr_pkg::ADDR_EPR1H, P[3], 1'b0);
    rdchk(iepr_pkg::ADDR_PR0H, P[1]);
    rdchk(iepr_pkg::ADDR_EPR1L, P[2]);
    e = '0;
    for (int i = 0; i < 8; i++) begin
      e[2 * ((i == 7) ? 15 : i) +: 2] = {P[1][i], P[0][i]};
    end
    for (int i = 0; i < 8; i++) begin
      e[2 * M1[i] +: 2] = {P[3][i], P[2][i]};
    end
    for (int i = 19; i < 24; i++) begin
      e[2 * i +: 2] = 2'b11;
    end
    cyc(2);
    chk("irq_level", lvl, e);
    // Enable gating, the reserved bit and the global gate.
    u_cpu.wr(iepr_pkg::ADDR_EEN2, 8'hff, 1'b1);
    rdchk(iepr_pkg::ADDR_EEN2, 8'hdf);
    for (int p = 0; p < 3; p++) begin
      u_cpu.wr(iepr_pkg::ADDR_EEN1, E1[p], 1'b0);
      u_cpu.wr(iepr_pkg::ADDR_EEN2, E2[p], 1'b0);
      sf_en = {8'h00, p == 0};
      gate = (p != 2);
      e = 48'hffffff;
      {e[2], e[15]} = 2'b00;
      for (int i = 0; i < 8; i++) begin
        e[M1[i]] = E1[p][i];
        if (i != 5) e[M2[i]] = E2[p][i];
      end
      e[10] = E1[p][3] & sf_en[0];
      if (!gate) e = '0;
      cyc(3);
      chk("irq_req", 48'(req), e);
    end
    // External 2 and 3 in every sense, trigger kind and enable.
    gate = 1'b1;
    pd = 1'b1;
    for (int m = 0; m < 16; m++) begin
      {k, pl, tg, en} = {32'(m[3]), m[2], m[1], m[0]};
      c = 8'({pl, en, 1'b0, tg}) << (4 * k);
      pb = 8'h02 << (4 * k);
      u_cpu.wr(XC, c, 1'b0);
      pin = 2'b11;
      pin[k] = ~pl;
      cyc(2);
      u_cpu.wr(XC, c, 1'b0);
      rdchk(XC, c);
      pin[k] = pl;
      cyc(3);
      rdchk(XC, c | pb);
      chk("irq_req", 48'(req[k ? 15 : 2]), 48'(en));
      chk("cpu_wake", 48'(wake), 48'(en));
      ack[k] = 1'b1;
      cyc(1);
      ack[k] = 1'b0;
      cyc(2);
      rdchk(XC, tg ? c : c | pb);
      pin[k] = ~pl;
      cyc(2);
      u_cpu.wr(XC, c | pb, 1'b0);
      rdchk(XC, c | pb);
      u_cpu.wr(XC, c, 1'b0);
      rdchk(XC, c);
    end
    // Break and modulator flags, polarity copies and PWM blocking.
    pd = 1'b0;
    u_cpu.wr(AX, 8'h03, 1'b0);
    cyc(2);
    chk("ext_polarity", 48'(pol), 48'(2'b11));
    for (int i = 0; i < 4; i++) begin
      ev[i] = 1'b1;
      cyc(1);
      ev[i] = 1'b0;
      cyc(2);
      rdchk(AX, 8'h03 | (8'h04 << ((i > 1) ? 2 : i)));
      chk("pwm_block", 48'(blk), 48'((i > 1) ? pwm_en : 6'h00));
      u_cpu.wr(AX, 8'h02, 1'b0);
      rdchk(AX, 8'h02);
      chk("ext_polarity", 48'(pol), 48'(2'b10));
      u_cpu.wr(AX, 8'h03, 1'b0);
    end
    complete_run();
  end
endmodule
